// ### shared/afh_regs.vh
// Constants for the host-side controller of the nine-bit async buffer.
// Assumes a 10 ns core clock; included by bare name from rtl files.
`ifndef AFH_REGS_VH
`define AFH_REGS_VH

// Register byte offsets
`define AFH_CTRL_OFS 8'h00
`define AFH_CMD_OFS 8'h04
`define AFH_WDATA_OFS 8'h08
`define AFH_RDATA_OFS 8'h0c
`define AFH_STATUS_OFS 8'h10

// Field positions
`define AFH_CTRL_DEPTH 0
`define AFH_CMD_POP 0
`define AFH_CMD_PLAYBACK 1
`define AFH_CMD_CLEAR 2
`define AFH_CMD_DROP_CLR 3
`define AFH_ST_BUSY 0
`define AFH_ST_EMPTY_N 1
`define AFH_ST_FULL_N 2
`define AFH_ST_HALF_N 3
`define AFH_ST_RVALID 4
`define AFH_ST_DROP 5
`define AFH_ST_DEPTH 6

// Reset values
`define AFH_CTRL_RST 1'h0
`define AFH_DATA_RST 9'h000

// Times in ns and derived cycle counts
`define AFH_CLK_NS 10
`define AFH_PULSE_NS 30
`define AFH_SETTLE_NS 30
`define AFH_PULSE_CYC ((`AFH_PULSE_NS + `AFH_CLK_NS - 1) / `AFH_CLK_NS)
`define AFH_SETTLE_CYC ((`AFH_SETTLE_NS + `AFH_CLK_NS - 1) / `AFH_CLK_NS)

`endif

// ### rtl/afh_ctrl.v
// Host controller driving a nine-bit asynchronous buffer through its pins.
// Assumes pins synchronous to core_clk and a ring of up to two devices.
//
// Function
// R1: Device stores nine-bit words in order.
// R2: Clear cycle empties device, flags reset.
// R3: Clear at power-up, strobes high around it.
// R4: Device shows free room by full high.
// R5: Push falling edge writes stable data; the device model stores in_data on the rising edge.
// R6: Device raises empty after first write.
// R7: Device drives half low past half.
// R8: Device releases half back at half.
// R9: Device drives full low on last write.
// R10: Device discards writes while full.
// R11: Device raises full after a read.
// R12: Reads on empty device are discarded.
// R13: Device floats outputs when idle or empty.
// R14: Last read floats outputs until next write.
// R15: Playback rewinds read pointer only.
// R16: Strobes stay high during and after playback.
// R17: Replayed reads advance, flags recomputed.
// R18: Standalone: chain input low, lead high.
// R19: Depth mode latched at clear, one lead.
// R20: Device pulses chain output at last location.
// R21: Host merges flags of chained devices.
// R22: Depth mode has no half flag, playback.
// R23: Pointers wrap; half pin is chain output.
`timescale 1ns/10ps
`include "afh_regs.vh"
`default_nettype none

module afh_ctrl (
  input wire core_clk,
  input wire rst,
  input wire ce,
  input wire [7:0] addr,
  input wire [31:0] wr_data,
  input wire wr_en,
  input wire rd_en,
  output reg [31:0] rd_data,
  output reg [8:0] in_data,
  output reg push_n,
  output reg pop_n,
  output reg clean_slate_n,
  output reg playback_n,
  output reg lead_device_n,
  output reg chain_in_n,
  output reg chain_in_oe,
  input wire [1:0] empty_ind_n,
  input wire [1:0] full_ind_n,
  input wire half_level_n,
  input wire [8:0] out_data
);

  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_PUSH = 6'h02;
  localparam [5:0] ST_POP = 6'h04;
  localparam [5:0] ST_CLEAR = 6'h08;
  localparam [5:0] ST_PLAY = 6'h10;
  localparam [5:0] ST_SETTLE = 6'h20;
  // Counts reckoned as integers, then cut to the counter width
  localparam integer PULSE_INT = `AFH_PULSE_CYC;
  localparam integer SETTLE_INT = `AFH_SETTLE_CYC;
  localparam [2:0] PULSE_CYC = PULSE_INT[2:0];
  localparam [2:0] SETTLE_CYC = SETTLE_INT[2:0];

  // Composite active-low flag: in depth mode all chained devices must agree; standalone takes device 0 only
  function afh_merge;
    input [1:0] flags_n;
    input depth;
    begin
      afh_merge = depth ? (|flags_n) : flags_n[0];
    end
  endfunction

  reg [5:0] state;
  reg [2:0] cnt;
  reg depth_mode;
  reg depth_latched;
  reg pend_push;
  reg pend_pop;
  reg pend_play;
  reg pend_clear;
  reg [8:0] wbuf;
  reg [8:0] rword;
  reg rvalid;
  reg dropped;
  reg empty_n;
  reg full_n;
  reg half_n;
  wire busy;
  wire wr_ctrl;
  wire wr_cmd;
  wire wr_wdata;
  wire cmd_pop;
  wire cmd_play;
  wire cmd_clear;
  wire drop_req;
  wire drop_launch;
  wire last_cnt;

  assign busy = (state != ST_IDLE) | pend_push | pend_pop | pend_play |
    pend_clear;
  assign wr_ctrl = wr_en & (addr == `AFH_CTRL_OFS);
  assign wr_cmd = wr_en & (addr == `AFH_CMD_OFS);
  assign wr_wdata = wr_en & (addr == `AFH_WDATA_OFS);
  assign cmd_pop = wr_cmd & wr_data[`AFH_CMD_POP];
  assign cmd_play = wr_cmd & wr_data[`AFH_CMD_PLAYBACK];
  assign cmd_clear = wr_cmd & wr_data[`AFH_CMD_CLEAR];
  assign last_cnt = (cnt == 3'h1);
  // Push, pop or replay order arriving while one of its kind is pending is lost
  assign drop_req = (wr_wdata & pend_push) | (cmd_pop & pend_pop) |
    (cmd_play & pend_play);
  // Refusals at launch: push when full, pop when empty
  assign drop_launch = (state == ST_IDLE) & ~pend_clear & ~pend_play &
    ((pend_push & ~full_n) | (~pend_push & pend_pop & ~empty_n));

  // Flag sampling; half flag is held high in depth mode
  always @(posedge core_clk) begin
    if (rst) begin
      empty_n <= 1'h0;
      full_n <= 1'h1;
      half_n <= 1'h1;
    end else if (ce) begin
      empty_n <= afh_merge(empty_ind_n, depth_latched); // R21
      full_n <= afh_merge(full_ind_n, depth_latched); // R21
      half_n <= depth_latched ? 1'h1 : half_level_n; // R22
    end
  end

  // Software registers and pending orders
  always @(posedge core_clk) begin
    if (rst) begin
      depth_mode <= `AFH_CTRL_RST;
      wbuf <= `AFH_DATA_RST;
      pend_push <= 1'h0;
      pend_pop <= 1'h0;
      pend_play <= 1'h0;
      pend_clear <= 1'h1; // R3
      dropped <= 1'h0;
      rd_data <= 32'h00000000;
    end else if (ce) begin
      if (wr_ctrl) begin
        depth_mode <= wr_data[`AFH_CTRL_DEPTH];
      end
      if (wr_wdata & ~pend_push) begin
        wbuf <= wr_data[8:0];
        pend_push <= 1'h1;
      end else if (state == ST_IDLE & ~pend_clear & ~pend_play) begin
        if (pend_push) begin
          pend_push <= 1'h0;
        end
      end
      if (cmd_pop & ~pend_pop) begin
        pend_pop <= 1'h1;
      end else if (state == ST_IDLE & ~pend_clear & ~pend_play &
          ~pend_push) begin
        pend_pop <= 1'h0;
      end
      if (cmd_play & ~pend_play & ~depth_latched) begin
        pend_play <= 1'h1; // R22
      end else if (state == ST_IDLE & ~pend_clear) begin
        pend_play <= 1'h0;
      end
      if (cmd_clear) begin
        pend_clear <= 1'h1;
      end else if (state == ST_IDLE) begin
        pend_clear <= 1'h0;
      end
      // Set wins over the clear in the same cycle
      if (drop_req | drop_launch | (cmd_play & depth_latched)) begin
        dropped <= 1'h1;
      end else if (wr_cmd & wr_data[`AFH_CMD_DROP_CLR]) begin
        dropped <= 1'h0;
      end
      // Read data stand in the cycle after the strobe only
      rd_data <= 32'h00000000;
      if (rd_en) begin
        case (addr)
          `AFH_CTRL_OFS: rd_data <= {31'h0, depth_mode};
          `AFH_RDATA_OFS: rd_data <= {23'h0, rword};
          `AFH_STATUS_OFS: rd_data <= {25'h0, depth_latched, dropped,
            rvalid, half_n, full_n, empty_n, busy};
          default: rd_data <= 32'h00000000;
        endcase
      end
    end
  end

  // Pin sequencer; strobes stay high outside their own pulse
  always @(posedge core_clk) begin
    if (rst) begin
      state <= ST_IDLE;
      cnt <= 3'h0;
      push_n <= 1'h1;
      pop_n <= 1'h1;
      clean_slate_n <= 1'h1;
      playback_n <= 1'h1;
      in_data <= `AFH_DATA_RST;
      rword <= `AFH_DATA_RST;
      rvalid <= 1'h0;
      depth_latched <= `AFH_CTRL_RST;
      lead_device_n <= 1'h1;
      chain_in_n <= 1'h0;
      chain_in_oe <= 1'h1;
    end else if (ce) begin
      if (rd_en & (addr == `AFH_RDATA_OFS)) begin
        rvalid <= 1'h0;
      end
      case (state)
        ST_IDLE: begin
          if (pend_clear) begin
            // Mode pins set up before the clear releases
            lead_device_n <= ~depth_mode; // R19
            chain_in_n <= 1'h0; // R18
            chain_in_oe <= ~depth_mode; // R19
            clean_slate_n <= 1'h0; // R3
            cnt <= PULSE_CYC;
            state <= ST_CLEAR;
          end else if (pend_play) begin
            playback_n <= 1'h0; // R16
            cnt <= PULSE_CYC;
            state <= ST_PLAY;
          end else if (pend_push & full_n) begin
            in_data <= wbuf; // R5
            push_n <= 1'h0; // R5
            cnt <= PULSE_CYC;
            state <= ST_PUSH;
          end else if (~pend_push & pend_pop & empty_n) begin
            pop_n <= 1'h0; // R12
            cnt <= PULSE_CYC;
            state <= ST_POP;
          end
        end
        ST_PUSH: begin
          cnt <= cnt - 3'h1;
          if (last_cnt) begin
            push_n <= 1'h1; // R5
            cnt <= SETTLE_CYC;
            state <= ST_SETTLE;
          end
        end
        ST_POP: begin
          cnt <= cnt - 3'h1;
          if (last_cnt) begin
            rword <= out_data; // R1
            rvalid <= 1'h1;
            pop_n <= 1'h1;
            cnt <= SETTLE_CYC;
            state <= ST_SETTLE;
          end
        end
        ST_CLEAR: begin
          cnt <= cnt - 3'h1;
          if (last_cnt) begin
            clean_slate_n <= 1'h1;
            depth_latched <= depth_mode; // R19
            rvalid <= 1'h0;
            cnt <= SETTLE_CYC; // R3
            state <= ST_SETTLE;
          end
        end
        ST_PLAY: begin
          cnt <= cnt - 3'h1;
          if (last_cnt) begin
            playback_n <= 1'h1;
            cnt <= SETTLE_CYC; // R16
            state <= ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          // Strobes held high so flags settle before the next launch
          cnt <= cnt - 3'h1;
          if (last_cnt) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// ### test/anbf_chk.sv
// Port checker for the host controller of the nine-bit buffer.
// Sees only controller ports; single device, run in standalone mode, then depth mode.
`timescale 1ns/10ps
`default_nettype none
module anbf_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [8:0] in_data,
  input wire logic push_n,
  input wire logic pop_n,
  input wire logic clean_slate_n,
  input wire logic playback_n,
  input wire logic chain_in_n,
  input wire logic lead_device_n,
  input wire logic [1:0] empty_ind_n,
  input wire logic [1:0] full_ind_n
);
  logic idle;
  // All device strobes released
  assign idle = push_n & pop_n & clean_slate_n & playback_n;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_push; $fell(push_n) |-> (!push_n)[*3] ##1 push_n; endproperty
  a_push: assert property (p_push) else $error("push width");
  property p_hold; !$past(push_n) |-> $stable(in_data); endproperty
  a_hold: assert property (p_hold) else $error("data moved");
  property p_one;
    $countones({push_n, pop_n, clean_slate_n, playback_n}) >= 3;
  endproperty
  a_one: assert property (p_one) else $error("strobe overlap");
  property p_full; (!full_ind_n[0])[*3] |=> !$fell(push_n); endproperty
  a_full: assert property (p_full) else $error("push on full");
  property p_empty; (!empty_ind_n[0])[*3] |=> !$fell(pop_n); endproperty
  a_empty: assert property (p_empty) else $error("pop on empty");
  property p_clr; $fell(clean_slate_n) |->
    (!clean_slate_n && push_n && pop_n)[*3] ##1 idle[*3]; endproperty
  a_clr: assert property (p_clr) else $error("clear cycle");
  property p_play; $fell(playback_n) |->
    (!playback_n && push_n && pop_n)[*3] ##1 idle[*3]; endproperty
  a_play: assert property (p_play) else $error("replay cycle");
  // Recovery gap; reset forcing strobes high is not a real rise
  property p_gap; ($rose(push_n) || $rose(pop_n)) && !$past(rst) |->
    idle[*3]; endproperty
  a_gap: assert property (p_gap) else $error("no recovery");
  property p_first; $fell(rst) |-> ##[1:2] !clean_slate_n; endproperty
  a_first: assert property (p_first) else $error("no clear");
  property p_gnd; !chain_in_n; endproperty
  a_gnd: assert property (p_gnd) else $error("chain input");
  // Mode pin must not move while the clear is low or as it releases
  property p_mode; !$past(clean_slate_n) |-> $stable(lead_device_n);
  endproperty
  a_mode: assert property (p_mode) else $error("mode moved");
  c_push: cover property ($fell(push_n));
  c_pop: cover property ($fell(pop_n));
  c_play: cover property ($fell(playback_n));
endmodule
bind afh_ctrl anbf_chk anbf_chk_i (.core_clk, .rst, .in_data, .push_n,
  .pop_n, .clean_slate_n, .playback_n, .chain_in_n, .lead_device_n,
  .empty_ind_n, .full_ind_n);
`default_nettype wire

// ### test/anbf_dev.sv
// Behavioural model of the buffer device, driven only by pin edges.
// Flags mirrored on both bits so the OR merge acts as one device.
`timescale 1ns/10ps
`default_nettype none
module anbf_dev #(parameter DEPTH = 8) (
  input wire logic push_n,
  input wire logic pop_n,
  input wire logic clean_slate_n,
  input wire logic playback_n,
  input wire logic lead_device_n,
  input wire logic [8:0] in_data,
  output logic [8:0] out_data,
  output logic [1:0] empty_ind_n,
  output logic [1:0] full_ind_n,
  output logic half_level_n
);
  logic [8:0] mem [0:DEPTH-1];
  logic [8:0] q = 9'h000;
  logic ef = 0, ff = 1, hf = 1, depth = 0, wr_ok = 0, rd_ok = 0, xo = 1;
  int wp = 0, rp = 0, cnt = 0, nw = 0;
  assign empty_ind_n = {ef, ef};
  assign full_ind_n = {ff, ff};
  // In depth mode the half pin carries the chain token pulse
  assign half_level_n = depth ? xo : hf;
  // Floating bus shows inverted word, never a held value
  assign out_data = (!pop_n && rd_ok) ? q : ~q;
  // Clear empties the array
  always @(negedge clean_slate_n) begin
    {wp, rp, cnt, nw} = '0;
    {ef, ff, hf} = 3'b011;
  end
  always @(posedge clean_slate_n) depth = !lead_device_n;
  // Full and half move on the falling write edge
  always @(negedge push_n) begin
    wr_ok = cnt < DEPTH;
    xo = !(wr_ok && depth && wp == DEPTH - 1);
    if (wr_ok) begin
      ff = cnt + 1 < DEPTH;
      hf = cnt + 1 <= DEPTH / 2;
    end
  end
  always @(posedge push_n) begin
    if (wr_ok) begin
      mem[wp] = in_data;
      wp = (wp + 1) % DEPTH;
      cnt = cnt + 1;
      nw = nw + 1;
      ef = 1;
    end
    xo = 1;
    wr_ok = 0;
  end
  always @(negedge pop_n) begin
    rd_ok = cnt > 0;
    xo = !(rd_ok && depth && rp == DEPTH - 1);
    if (rd_ok) begin
      q = mem[rp];
      ef = cnt > 1;
    end
  end
  always @(posedge pop_n) begin
    if (rd_ok) begin
      rp = (rp + 1) % DEPTH;
      cnt = cnt - 1;
      ff = 1;
      hf = cnt <= DEPTH / 2;
    end
    xo = 1;
    rd_ok = 0;
  end
  // Replay rewinds reads only; flags follow the pointers
  always @(negedge playback_n) begin
    if (!depth) begin
      rp = 0;
      cnt = nw;
      {ef, ff, hf} = {cnt > 0, cnt < DEPTH, cnt <= DEPTH / 2};
    end
  end
endmodule
`default_nettype wire

// ### test/async_nine_bit_fifo_bench.sv
// Self-checking bench: controller plus device model, standalone mode, then depth mode.
// Register offsets come from the shared header; fields are written as literals.
`timescale 1ns/10ps
`include "afh_regs.vh"
`default_nettype none
module async_nine_bit_fifo_bench;
  localparam int DEPTH = 8;
  logic core_clk = 0, rst = 1, ce = 1, wr_en = 0, rd_en = 0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wr_data = 32'h0, rd_data, st;
  logic [8:0] in_data, out_data, exp_q [$], all_q [$];
  logic [1:0] empty_ind_n, full_ind_n;
  logic push_n, pop_n, clean_slate_n, playback_n, lead_device_n;
  logic chain_in_n, chain_in_oe, half_level_n;
  logic [15:0] r = 16'haa67;
  int err_count = 0, total_checks = 0, cyc = 0;
  afh_ctrl afh_ctrl_i (.core_clk, .rst, .ce, .addr, .wr_data, .wr_en,
    .rd_en, .rd_data, .in_data, .push_n, .pop_n, .clean_slate_n,
    .playback_n, .lead_device_n, .chain_in_n, .chain_in_oe,
    .empty_ind_n, .full_ind_n, .half_level_n, .out_data);
  anbf_dev #(.DEPTH(DEPTH)) anbf_dev_i (.push_n, .pop_n, .clean_slate_n,
    .playback_n, .lead_device_n, .in_data, .out_data, .empty_ind_n,
    .full_ind_n, .half_level_n);
  initial forever #5 core_clk = ~core_clk;
  // Hang guard, far above the expected run
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      complete_run;
    end
  end
  function automatic logic [15:0] lfsr(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Expected {half_n, full_n, empty_n} for a fill level
  function automatic logic [2:0] flags(int n);
    return {n <= DEPTH / 2, n < DEPTH, n > 0};
  endfunction
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s exp %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge core_clk);
    wr_en <= 1;
    addr <= a;
    wr_data <= d;
    @(posedge core_clk);
    wr_en <= 0;
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge core_clk);
    rd_en <= 1;
    addr <= a;
    @(posedge core_clk);
    rd_en <= 0;
    #1 st = rd_data;
  endtask
  // Poll status until the controller is no longer busy
  task automatic idle;
    int n = 0;
    do begin
      rd(`AFH_STATUS_OFS);
      n++;
    end while (st[0] !== 1'b0 && n < 50);
    // A controller that never goes idle counts as a mismatch
    if (st[0] !== 1'b0) err_count++;
  endtask
  task automatic pop_chk;
    wr(`AFH_CMD_OFS, 32'h1);
    idle;
    chk("rvalid", st[4], 1'b1);
    rd(`AFH_RDATA_OFS);
    chk("word", st[8:0], exp_q.pop_front());
    rd(`AFH_STATUS_OFS);
    chk("drain", st[4:1], {1'b0, flags(exp_q.size())});
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 0;
    idle;
    chk("cleared", st[3:1], flags(0));
    chk("pins", {chain_in_oe, chain_in_n, lead_device_n}, 3'b101);
    rd(8'h14);
    chk("unmapped", st, 32'h0);
    wr(`AFH_CMD_OFS, 32'h1);
    idle;
    chk("empty pop", st[5], 1'b1);
    wr(`AFH_CMD_OFS, 32'h8);
    // Fill one past capacity with random words
    for (int i = 1; i <= DEPTH + 1; i++) begin
      r = lfsr(r);
      wr(`AFH_WDATA_OFS, {23'h0, r[8:0]});
      if (i <= DEPTH) exp_q.push_back(r[8:0]);
      idle;
      chk("fill", st[3:1], flags(exp_q.size()));
      chk("refuse", st[5], i > DEPTH);
    end
    all_q = exp_q;
    wr(`AFH_CMD_OFS, 32'h8);
    repeat (5) pop_chk;
    // Replay from the first location, then drain fully
    wr(`AFH_CMD_OFS, 32'h2);
    idle;
    chk("replay", st[3:1], flags(DEPTH));
    exp_q = all_q;
    repeat (DEPTH) pop_chk;
    // Frozen controller must ignore a push order
    @(posedge core_clk);
    ce <= 0;
    wr(`AFH_WDATA_OFS, 32'h5);
    ce <= 1;
    idle;
    chk("frozen", st[3:0], {flags(0), 1'b0});
    wr(`AFH_CTRL_OFS, 32'h1);
    rd(`AFH_CTRL_OFS);
    chk("ctrl", st, 32'h1);
    wr(`AFH_CMD_OFS, 32'h4);
    idle;
    chk("depth", {st[6], lead_device_n}, 2'b10);
    chk("oe", chain_in_oe, 1'b0);
    wr(`AFH_CMD_OFS, 32'h2);
    idle;
    chk("no replay", st[5], 1'b1);
    complete_run;
  end
endmodule
`default_nettype wire
